// File: pkg/phy_status_pkg.sv
package phy_status_pkg;

  // register addresses (5-bit management register numbers)
  localparam logic [4:0] cfg_reg_addr    = 5'h13;  // configuration register
  localparam logic [4:0] status_reg_addr = 5'h14;  // chip status register

  // chip status field positions
  localparam int unsigned st_link_pos   = 13;  // live link
  localparam int unsigned st_duplex_pos = 12;  // full duplex
  localparam int unsigned st_speed_pos  = 11;  // 100 Mbps
  localparam int unsigned st_aneg_pos   = 9;   // negotiation complete, latch high
  localparam int unsigned st_page_pos   = 8;   // page received, latch high
  localparam int unsigned st_lowv_pos   = 2;   // low supply fault

  // configuration field positions that take strap defaults
  localparam int unsigned cf_rptr_pos   = 13;  // repeater / dte mode
  localparam int unsigned cf_ltst_pos   = 8;   // link test disable
  localparam int unsigned cf_sym_pos    = 4;   // symbol / nibble mode
  localparam int unsigned cf_scr_pos    = 3;   // scrambler bypass
  localparam int unsigned cf_fx_pos     = 2;   // fiber select

  // reset values
  localparam logic [15:0] cfg_reset_val  = 16'h0000;  // before strap load
  localparam logic [15:0] cfg_write_mask = 16'h7FFD;  // reserved bits 15 and 1 stay 0

  // identical code words needed for a received page
  localparam logic [1:0] page_match_cnt = 2'h3;

  // event inputs from the physical layer
  typedef struct packed {
    logic link_up;     // live link state
    logic full_dup;    // resolved duplex
    logic speed_100;   // resolved speed
    logic aneg_done;   // negotiation finished pulse/level
    logic cw_valid;    // link code word strobe
    logic [15:0] cw;   // link code word value
    logic low_volt;    // undervoltage fault
  } phy_evt_t;

  // strap pins
  typedef struct packed {
    logic strap_pin_one;    // repeater mode
    logic strap_pin_two;    // symbol mode
    logic strap_pin_three;  // scrambler bypass
    logic strap_pin_four;   // fiber select
    logic link_test_strap;  // link test disable
    logic aneg_en;          // auto-negotiation enable strap
  } strap_t;

endpackage : phy_status_pkg

// File: src/phy_chip_status.sv
module phy_chip_status
  import phy_status_pkg::*;
(
  input  wire logic        clk,        // 50 MHz device clock
  input  wire logic        rst_b,      // async reset, active low
  input  wire logic        clk_en,     // freezes all state when low
  input  wire phy_evt_t    evt,        // physical layer state, same clock
  input  wire strap_t      straps,     // strap pins, asynchronous
  input  wire logic        reg_rd,     // management read strobe, one cycle
  input  wire logic        reg_wr,     // management write strobe, one cycle
  input  wire logic [4:0]  reg_addr,   // management register number
  input  wire logic [15:0] reg_wdata,  // management write data
  output logic      [15:0] reg_rdata,  // read data, registered
  output logic      [15:0] cfg_out,    // configuration bits to the datapath
  output logic             fiber_sel   // 1 fiber interface, 0 twisted pair
);

  // strap synchroniser and capture
  strap_t       strap_s1_q, strap_s1_d;   // first sync stage
  strap_t       strap_s2_q, strap_s2_d;   // second sync stage
  logic         in_rst_q, in_rst_d;       // high until first edge after release
  // configuration and latched status
  logic [15:0]  cfg_q, cfg_d;             // configuration register
  logic         aneg_lh_q, aneg_lh_d;     // latch-high negotiation complete
  logic         page_lh_q, page_lh_d;     // latch-high page received
  logic [15:0]  last_cw_q, last_cw_d;     // previous code word
  logic [1:0]   cw_cnt_q, cw_cnt_d;       // identical word run length
  logic [15:0]  rdata_q, rdata_d;         // read data register
  logic [15:0]  status_w;                 // assembled status word
  logic         st_rd;                    // read of status register

  // address match used by reads and writes
  function automatic logic hit(input logic [4:0] a, input logic [4:0] r);
    hit = (a == r);
  endfunction

  // status word assembly, reserved bits zero
  always_comb begin
    status_w = 16'h0000;
    status_w[st_link_pos]   = evt.link_up;
    status_w[st_duplex_pos] = evt.full_dup;
    status_w[st_speed_pos]  = evt.speed_100;
    status_w[st_aneg_pos]   = aneg_lh_q;
    status_w[st_page_pos]   = page_lh_q;
    status_w[st_lowv_pos]   = evt.low_volt;
  end

  assign st_rd = reg_rd && hit(reg_addr, status_reg_addr);

  // strap sync next values
  always_comb begin
    strap_s1_d = straps;
    strap_s2_d = strap_s1_q;
  end

  // strap sync registers, no reset so the pins are tracked while reset is held
  always_ff @(posedge clk) begin
    if (clk_en) begin
      strap_s1_q <= strap_s1_d;
      strap_s2_q <= strap_s2_d;
    end
  end

  // configuration next value
  always_comb begin
    cfg_d    = cfg_q;
    in_rst_d = 1'b0;  // strap load happens once per release
    if (in_rst_q) begin
      cfg_d = cfg_reset_val;
      cfg_d[cf_rptr_pos] = strap_s2_q.strap_pin_one;
      cfg_d[cf_ltst_pos] = strap_s2_q.aneg_en ? 1'b0 : strap_s2_q.link_test_strap;
      cfg_d[cf_sym_pos]  = strap_s2_q.strap_pin_two;
      cfg_d[cf_scr_pos]  = strap_s2_q.strap_pin_three;
      cfg_d[cf_fx_pos]   = strap_s2_q.aneg_en ? 1'b0 : strap_s2_q.strap_pin_four;
    end else if (reg_wr && hit(reg_addr, cfg_reg_addr)) begin
      // software write, reserved bits forced low
      cfg_d = reg_wdata & cfg_write_mask;
    end
  end

  // latching status and code word matching
  always_comb begin
    aneg_lh_d = aneg_lh_q;
    page_lh_d = page_lh_q;
    last_cw_d = last_cw_q;
    cw_cnt_d  = cw_cnt_q;
    if (st_rd) begin
      aneg_lh_d = 1'b0;
      page_lh_d = 1'b0;
    end
    // code word run counting
    if (evt.cw_valid) begin
      last_cw_d = evt.cw;
      if (cw_cnt_q != 2'h0 && evt.cw == last_cw_q) begin
        cw_cnt_d = (cw_cnt_q == page_match_cnt) ? cw_cnt_q : cw_cnt_q + 2'h1;
      end else begin
        cw_cnt_d = 2'h1;
      end
    end
    if (evt.aneg_done) begin
      aneg_lh_d = 1'b1;
    end
    if (evt.cw_valid && cw_cnt_d == page_match_cnt && cw_cnt_q != page_match_cnt) begin
      page_lh_d = 1'b1;
    end
  end

  // read data next value
  always_comb begin
    rdata_d = rdata_q;
    if (reg_rd) begin
      if (hit(reg_addr, status_reg_addr)) begin
        rdata_d = status_w;
      end else if (hit(reg_addr, cfg_reg_addr)) begin
        rdata_d = cfg_q;
      end else begin
        rdata_d = 16'h0000;  // other registers live elsewhere
      end
    end
  end

  // main state registers
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      cfg_q     <= cfg_reset_val;
      in_rst_q  <= 1'b1;
      aneg_lh_q <= 1'b0;
      page_lh_q <= 1'b0;
      last_cw_q <= 16'h0000;
      cw_cnt_q  <= 2'h0;
      rdata_q   <= 16'h0000;
    end else if (clk_en) begin
      cfg_q     <= cfg_d;
      in_rst_q  <= in_rst_d;
      aneg_lh_q <= aneg_lh_d;
      page_lh_q <= page_lh_d;
      last_cw_q <= last_cw_d;
      cw_cnt_q  <= cw_cnt_d;
      rdata_q   <= rdata_d;
    end
  end

  assign reg_rdata = rdata_q;
  assign cfg_out   = cfg_q;
  assign fiber_sel = cfg_q[cf_fx_pos];

  // live link in read data
  property p_link_live;
    @(posedge clk) disable iff (!rst_b)
      (clk_en && st_rd) |=> reg_rdata[st_link_pos] == $past(evt.link_up);
  endproperty
  a_link_live: assert property (p_link_live) else $error("link bit not live");

  property p_mode_bits;
    @(posedge clk) disable iff (!rst_b)
      (clk_en && st_rd) |=> reg_rdata[12:11] == {$past(evt.full_dup), $past(evt.speed_100)};
  endproperty
  a_mode_bits: assert property (p_mode_bits) else $error("mode bits wrong");

  property p_aneg_set;
    @(posedge clk) disable iff (!rst_b)
      (clk_en && evt.aneg_done) |=> aneg_lh_q;
  endproperty
  a_aneg_set: assert property (p_aneg_set) else $error("aneg not latched");

  property p_page_set;
    @(posedge clk) disable iff (!rst_b)
      (clk_en && evt.cw_valid && cw_cnt_q == 2'h2 && evt.cw == last_cw_q) |=> page_lh_q;
  endproperty
  a_page_set: assert property (p_page_set) else $error("page not latched");

  property p_lh_clear;
    @(posedge clk) disable iff (!rst_b)
      (clk_en && st_rd && !evt.aneg_done) |=> !aneg_lh_q;
  endproperty
  a_lh_clear: assert property (p_lh_clear) else $error("latch not cleared");

  property p_lh_hold;
    @(posedge clk) disable iff (!rst_b)
      (page_lh_q && !(clk_en && st_rd)) |=> page_lh_q;
  endproperty
  a_lh_hold: assert property (p_lh_hold) else $error("latch dropped early");

  property p_lowv;
    @(posedge clk) disable iff (!rst_b)
      (clk_en && st_rd) |=> reg_rdata[st_lowv_pos] == $past(evt.low_volt);
  endproperty
  a_lowv: assert property (p_lowv) else $error("low voltage bit wrong");

  property p_strap_load;
    @(posedge clk) disable iff (!rst_b)
      (clk_en && in_rst_q) |=> cfg_q[cf_rptr_pos] == $past(strap_s2_q.strap_pin_one)
        && cfg_q[cf_sym_pos] == $past(strap_s2_q.strap_pin_two)
        && cfg_q[cf_scr_pos] == $past(strap_s2_q.strap_pin_three);
  endproperty
  a_strap_load: assert property (p_strap_load) else $error("strap default wrong");

  property p_aneg_defaults;
    @(posedge clk) disable iff (!rst_b)
      (clk_en && in_rst_q && strap_s2_q.aneg_en) |=> !cfg_q[cf_ltst_pos] && !fiber_sel;
  endproperty
  a_aneg_defaults: assert property (p_aneg_defaults) else $error("aneg default not 0");

  property p_reserved;
    @(posedge clk) disable iff (!rst_b)
      (clk_en && st_rd) |=> (reg_rdata & 16'hC4FB) == 16'h0000;
  endproperty
  a_reserved: assert property (p_reserved) else $error("reserved bit set");

  property p_ltst_strap;
    @(posedge clk) disable iff (!rst_b)
      (clk_en && in_rst_q && !strap_s2_q.aneg_en)
        |=> cfg_q[cf_ltst_pos] == $past(strap_s2_q.link_test_strap);
  endproperty
  a_ltst_strap: assert property (p_ltst_strap) else $error("link test default wrong");

  property p_fx_strap;
    @(posedge clk) disable iff (!rst_b)
      (clk_en && in_rst_q && !strap_s2_q.aneg_en)
        |=> fiber_sel == $past(strap_s2_q.strap_pin_four);
  endproperty
  a_fx_strap: assert property (p_fx_strap) else $error("fiber default wrong");

  property p_fiber_wr;
    @(posedge clk) disable iff (!rst_b)
      (clk_en && !in_rst_q && reg_wr && hit(reg_addr, cfg_reg_addr))
        |=> fiber_sel == $past(reg_wdata[cf_fx_pos]);
  endproperty
  a_fiber_wr: assert property (p_fiber_wr) else $error("fiber select wrong");

  property p_cfg_wr;
    @(posedge clk) disable iff (!rst_b)
      (clk_en && !in_rst_q && reg_wr && hit(reg_addr, cfg_reg_addr))
        |=> cfg_q == ($past(reg_wdata) & cfg_write_mask);
  endproperty
  a_cfg_wr: assert property (p_cfg_wr) else $error("config write wrong");

  property p_status_ro;
    @(posedge clk) disable iff (!rst_b)
      (clk_en && !in_rst_q && reg_wr && hit(reg_addr, status_reg_addr)) |=> $stable(cfg_q);
  endproperty
  a_status_ro: assert property (p_status_ro) else $error("status write landed");

  property p_cfg_rd;
    @(posedge clk) disable iff (!rst_b)
      (clk_en && reg_rd && hit(reg_addr, cfg_reg_addr)) |=> reg_rdata == $past(cfg_q);
  endproperty
  a_cfg_rd: assert property (p_cfg_rd) else $error("config read wrong");

  property p_unmapped;
    @(posedge clk) disable iff (!rst_b)
      (clk_en && reg_rd && !hit(reg_addr, cfg_reg_addr) && !hit(reg_addr, status_reg_addr))
        |=> reg_rdata == 16'h0000;
  endproperty
  a_unmapped: assert property (p_unmapped) else $error("unmapped not zero");

  property p_page_early;
    @(posedge clk) disable iff (!rst_b)
      (!page_lh_q && !(clk_en && evt.cw_valid && cw_cnt_q == 2'h2 && evt.cw == last_cw_q))
        |=> !page_lh_q;
  endproperty
  a_page_early: assert property (p_page_early) else $error("page set early");

  property p_page_clear;
    @(posedge clk) disable iff (!rst_b)
      (clk_en && st_rd && !(evt.cw_valid && cw_cnt_q == 2'h2 && evt.cw == last_cw_q))
        |=> !page_lh_q;
  endproperty
  a_page_clear: assert property (p_page_clear) else $error("page not cleared");

  property p_aneg_hold;
    @(posedge clk) disable iff (!rst_b)
      (aneg_lh_q && !(clk_en && st_rd)) |=> aneg_lh_q;
  endproperty
  a_aneg_hold: assert property (p_aneg_hold) else $error("aneg dropped early");

  property p_freeze;
    @(posedge clk) disable iff (!rst_b)
      !clk_en |=> $stable(reg_rdata) && $stable(cfg_q)
        && $stable(aneg_lh_q) && $stable(page_lh_q);
  endproperty
  a_freeze: assert property (p_freeze) else $error("state moved while frozen");

endmodule : phy_chip_status

// File: verification/mgmt_host.sv
module mgmt_host (
  input  wire logic        clk,        // device clock
  input  wire logic [15:0] reg_rdata,  // read data from the device
  output logic             reg_rd,     // read strobe
  output logic             reg_wr,     // write strobe
  output logic      [4:0]  reg_addr,   // register number
  output logic      [15:0] reg_wdata   // write data
);
  timeunit 1ns;
  timeprecision 100ps;

  // idle bus from time zero
  initial begin
    reg_rd    = 1'b0;
    reg_wr    = 1'b0;
    reg_addr  = 5'h00;
    reg_wdata = 16'h0000;
  end

  // one access held for one edge, then a scrambled idle bus
  task automatic xfer(input logic wr, input logic [4:0] a, input logic [15:0] w,
                      output logic [15:0] d);
    @(posedge clk);
    #1;
    reg_rd    = ~wr;
    reg_wr    = wr;
    reg_addr  = a;
    reg_wdata = w;
    @(posedge clk);
    #1;
    reg_rd    = 1'b0;
    reg_wr    = 1'b0;
    reg_addr  = ~a;
    reg_wdata = ~w;
    // read data stands until the next read, so one spare edge is safe
    @(posedge clk);
    #1;
    d = reg_rdata;
  endtask
endmodule // mgmt_host

// File: verification/tb.sv
module tb
  import phy_status_pkg::*;
;
  timeunit 1ns;
  timeprecision 100ps;

  logic clk = 1'b0;           // 50 MHz clock
  logic rst_b = 1'b0;         // reset, active low
  logic clk_en = 1'b1;        // run enable
  phy_evt_t evt = '0;         // physical layer state
  strap_t straps = '0;        // strap pins
  logic reg_rd, reg_wr;       // management strobes
  logic [4:0] reg_addr;       // register number
  logic [15:0] reg_wdata, reg_rdata, cfg_out, d, a, w;
  logic fiber_sel;            // interface select
  logic [15:0] lfsr_q = 16'hFC82;  // random source
  strap_t s;                  // strap pattern under test
  int fail_count = 0;
  int n_compared = 0;

  always #10 clk = ~clk;

  mgmt_host host (.clk(clk), .reg_rdata(reg_rdata), .reg_rd(reg_rd), .reg_wr(reg_wr),
                  .reg_addr(reg_addr), .reg_wdata(reg_wdata));
  phy_chip_status uut (.clk(clk), .rst_b(rst_b), .clk_en(clk_en), .evt(evt),
                       .straps(straps), .reg_rd(reg_rd), .reg_wr(reg_wr),
                       .reg_addr(reg_addr), .reg_wdata(reg_wdata),
                       .reg_rdata(reg_rdata), .cfg_out(cfg_out), .fiber_sel(fiber_sel));

  // next random word
  function automatic logic [15:0] rnd();
    lfsr_q = {lfsr_q[14:0], lfsr_q[15] ^ lfsr_q[13] ^ lfsr_q[12] ^ lfsr_q[10]};
    return lfsr_q;
  endfunction

  // expected configuration after reset
  function automatic logic [15:0] cfg_exp(strap_t p);
    logic [15:0] r;
    r = 16'h0000;
    r[cf_rptr_pos] = p.strap_pin_one;
    r[cf_ltst_pos] = p.link_test_strap & ~p.aneg_en;
    r[cf_sym_pos]  = p.strap_pin_two;
    r[cf_scr_pos]  = p.strap_pin_three;
    r[cf_fx_pos]   = p.strap_pin_four & ~p.aneg_en;
    return r;
  endfunction

  // expected status word
  function automatic logic [15:0] st_exp(logic an, logic pg);
    logic [15:0] r;
    r = 16'h0000;
    r[st_link_pos]   = evt.link_up;
    r[st_duplex_pos] = evt.full_dup;
    r[st_speed_pos]  = evt.speed_100;
    r[st_aneg_pos]   = an;
    r[st_page_pos]   = pg;
    r[st_lowv_pos]   = evt.low_volt;
    return r;
  endfunction

  task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
    n_compared++;
    if (seen !== exp) begin
      fail_count++;
      $display("wrong value %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic rd(input logic [4:0] ad);
    host.xfer(1'b0, ad, 16'h0000, d);
  endtask

  // one code word strobe per edge, back to back
  task automatic cw(input logic [15:0] v);
    @(posedge clk);
    #1;
    evt.cw_valid = 1'b1;
    evt.cw       = v;
  endtask

  task automatic cw_end();
    @(posedge clk);
    #1;
    evt.cw_valid = 1'b0;
  endtask

  task automatic complete_run();
    $display("compared %0d mismatches %0d", n_compared, fail_count);
    if (fail_count == 0 && n_compared > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask

  // watchdog well beyond the expected run
  initial begin
    #200000;
    fail_count++;
    complete_run();
  end

  initial begin
    // strap defaults, negotiation off then on, second reset
    for (int k = 0; k < 2; k++) begin
      a = rnd();
      s = strap_t'(a[5:0]);
      s.strap_pin_four  = 1'b1;
      s.link_test_strap = 1'b1;
      s.aneg_en         = k[0];
      @(posedge clk);
      #1;
      straps = s;
      rst_b  = 1'b0;
      repeat (4) @(posedge clk);
      #1;
      rst_b = 1'b1;
      repeat (4) @(posedge clk);
      #1;
      check("cfg_out", cfg_out, cfg_exp(s));
      check("link test default", {15'h0, cfg_out[cf_ltst_pos]}, {15'h0, ~s.aneg_en});
      check("fiber_sel", {15'h0, fiber_sel}, {15'h0, s.strap_pin_four & ~s.aneg_en});
      rd(cfg_reg_addr);
      check("cfg read", d, cfg_exp(s));
    end
    // live bits at random, reserved bits zero
    for (int i = 0; i < 12; i++) begin
      a = rnd();
      @(posedge clk);
      #1;
      {evt.link_up, evt.full_dup, evt.speed_100, evt.low_volt} = a[3:0];
      rd(status_reg_addr);
      check("status live", d, st_exp(1'b0, 1'b0));
    end
    // completion latches, survives a frozen read, then clears on read
    @(posedge clk);
    #1;
    evt.aneg_done = 1'b1;
    @(posedge clk);
    #1;
    evt.aneg_done = 1'b0;
    clk_en        = 1'b0;
    rd(status_reg_addr);
    check("frozen read", d, st_exp(1'b0, 1'b0));
    clk_en = 1'b1;
    rd(status_reg_addr);
    check("aneg latched", d, st_exp(1'b1, 1'b0));
    rd(status_reg_addr);
    check("aneg cleared", d, st_exp(1'b0, 1'b0));
    // completion in the same cycle as a read: set wins
    fork
      rd(status_reg_addr);
      begin
        @(posedge clk);
        #1;
        evt.aneg_done = 1'b1;
        @(posedge clk);
        #1;
        evt.aneg_done = 1'b0;
      end
    join
    check("aneg during read", d, st_exp(1'b0, 1'b0));
    rd(status_reg_addr);
    check("aneg set wins", d, st_exp(1'b1, 1'b0));
    rd(status_reg_addr);
    check("aneg cleared again", d, st_exp(1'b0, 1'b0));
    // a differing word restarts the identical-word count
    a = rnd();
    cw(a);
    cw(a);
    cw(~a);
    cw(~a);
    cw_end();
    rd(status_reg_addr);
    check("page early", d, st_exp(1'b0, 1'b0));
    cw(~a);
    cw_end();
    rd(status_reg_addr);
    check("page latched", d, st_exp(1'b0, 1'b1));
    rd(status_reg_addr);
    check("page cleared", d, st_exp(1'b0, 1'b0));
    for (int i = 0; i < 4; i++) begin
      w = rnd();
      host.xfer(1'b1, cfg_reg_addr, w, d);
      check("cfg write", cfg_out, w & cfg_write_mask);
      check("fiber write", {15'h0, fiber_sel}, {15'h0, w[cf_fx_pos]});
    end
    host.xfer(1'b1, status_reg_addr, 16'hFFFF, d);
    check("cfg after status write", cfg_out, w & cfg_write_mask);
    rd(status_reg_addr);
    check("status ro", d, st_exp(1'b0, 1'b0));
    rd(5'h1F);
    check("unmapped", d, 16'h0000);
    complete_run();
  end
endmodule // tb
